// ### pkg/sacp_pkg.sv
// Shared constants and carrier types for the SAR converter controller
package sacp_pkg;
	// Register indices; bus byte address is four times the index
	localparam logic [15:0] IDX_RESULT = 16'hff08;
	localparam logic [15:0] IDX_MODE = 16'hff28;
	localparam logic [15:0] IDX_CHAN = 16'hff29;
	localparam logic [15:0] IDX_PFMODE = 16'hff2a;
	localparam logic [15:0] IDX_THRESH = 16'hff2b;
	localparam int MODE_RUN_BIT = 7;
	localparam int MODE_TSEL_LSB = 3;
	localparam int MODE_REF_BIT = 0;
	localparam int PF_EN_BIT = 7;
	localparam int PF_DIR_BIT = 6;
	localparam int RES_W = 10;
	localparam int PAD_W = 6;
	localparam int NCHAN = 8;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Conversion lengths in clock periods per time code
	localparam logic [8:0] LEN_C0 = 9'h120;
	localparam logic [8:0] LEN_C1 = 9'h0f0;
	localparam logic [8:0] LEN_C2 = 9'h0c0;
	localparam logic [8:0] LEN_C4 = 9'h090;
	localparam logic [8:0] LEN_C5 = 9'h078;
	localparam logic [8:0] LEN_C6 = 9'h060;
	// Two sampling steps plus ten bit decisions
	localparam logic [8:0] STEPS_PER_CONV = 9'h00c;
	localparam logic [3:0] SAMPLE_STEPS = 4'h2;
	localparam logic [3:0] PHASE_LAST = 4'hb;
	localparam logic [9:0] MSB_TRIAL = 10'h200;

	typedef struct packed {
		logic run;
		logic [2:0] tsel;
		logic ref_en;
	} sacp_mode_t;

	typedef struct packed {
		logic en;
		logic dir;
	} sacp_pf_t;

	// Controls toward sample-and-hold and resistor-string tap
	typedef struct packed {
		logic sample;
		logic hold;
		logic [9:0] dac_code;
	} sacp_afe_t;

	typedef enum logic [1:0] {st_stop, st_wait, st_run} sacp_conv_state_t;

	function automatic logic [8:0] sacp_conv_len(input logic [2:0] code);
		unique case (code)
			3'h0: sacp_conv_len = LEN_C0;
			3'h1: sacp_conv_len = LEN_C1;
			3'h2: sacp_conv_len = LEN_C2;
			3'h4: sacp_conv_len = LEN_C4;
			3'h5: sacp_conv_len = LEN_C5;
			3'h6: sacp_conv_len = LEN_C6;
			// Prohibited codes fall back to the slowest setting
			default: sacp_conv_len = LEN_C0;
		endcase
	endfunction : sacp_conv_len
endpackage : sacp_pkg

// ### rtl/sacp_sar_seq.sv
// Successive-approximation sequencer: sampling, ten decisions, done pulse
`timescale 1ns/1ns
`default_nettype none
module sacp_sar_seq (
	input wire logic core_clk, // Converter clock
	input wire logic rst, // Async reset, active high
	input wire logic run, // Conversion enabled
	input wire logic restart, // Abort current conversion
	input wire logic [2:0] tsel, // Conversion time code
	input wire logic comp_ge, // Comparator: input at or above tap
	output sacp_pkg::sacp_afe_t afe, // Sample/hold and tap code
	output logic [9:0] result_now, // Final code, valid with done
	output logic done // Last decision cycle
);
	typedef enum logic [1:0] {sq_idle, sq_sample, sq_convert} sacp_seq_t;
	sacp_seq_t seq_reg;
	logic [3:0] phase_reg;
	logic [4:0] step_cnt_reg;
	logic [9:0] sar_reg;
	logic [8:0] conv_len;
	wire logic [4:0] step_len;
	wire logic step_last;
	wire logic [3:0] bit_idx;
	wire logic active;

	assign conv_len = sacp_pkg::sacp_conv_len(tsel);
	assign step_len = 5'(conv_len / sacp_pkg::STEPS_PER_CONV);
	assign step_last = step_cnt_reg == step_len - 5'h1;
	assign bit_idx = sacp_pkg::PHASE_LAST - phase_reg;
	assign active = seq_reg != sq_idle;
	assign done = seq_reg == sq_convert && phase_reg == sacp_pkg::PHASE_LAST && step_last;
	assign result_now = sar_reg | {9'h000, comp_ge};
	assign afe.sample = seq_reg == sq_sample;
	assign afe.hold = seq_reg == sq_convert;
	assign afe.dac_code = afe.hold ? (sar_reg | (10'h001 << bit_idx)) : 10'h000;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			seq_reg <= sq_idle;
			phase_reg <= 4'h0;
			step_cnt_reg <= 5'h00;
			sar_reg <= 10'h000;
		end else if (!run || restart || !active) begin
			// Restart always passes through idle for a clean sample
			seq_reg <= (run && !restart) ? sq_sample : sq_idle;
			phase_reg <= 4'h0;
			step_cnt_reg <= 5'h00;
			sar_reg <= 10'h000;
		end else if (!step_last) begin
			step_cnt_reg <= step_cnt_reg + 5'h01;
		end else begin
			step_cnt_reg <= 5'h00;
			if (done) begin
				seq_reg <= sq_sample;
				phase_reg <= 4'h0;
				sar_reg <= 10'h000;
			end else begin
				phase_reg <= phase_reg + 4'h1;
				if (phase_reg == sacp_pkg::SAMPLE_STEPS - 4'h1)
					seq_reg <= sq_convert;
				if (seq_reg == sq_convert)
					sar_reg[bit_idx] <= comp_ge;
			end
		end
	end

	// Helper: cycles since the current sample phase began
	logic [8:0] cyc_reg;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			cyc_reg <= 9'h000;
		else
			cyc_reg <= (!active || done || restart || !run) ? 9'h000 : cyc_reg + 9'h001;
	end

	chk_conv_length: assert property (@(posedge core_clk) disable iff (rst)
		done |-> cyc_reg == conv_len - 9'h001)
		else $error("conversion length differs from selected time code");
	chk_msb_first: assert property (@(posedge core_clk) disable iff (rst)
		$rose(afe.hold) |-> afe.dac_code == sacp_pkg::MSB_TRIAL)
		else $error("first trial is not the MSB");
	chk_hold_through: assert property (@(posedge core_clk) disable iff (rst)
		afe.hold && !done && run && !restart |=> afe.hold && !afe.sample)
		else $error("hold released before conversion end");
	chk_back_to_back: assert property (@(posedge core_clk) disable iff (rst)
		done && run && !restart |=> afe.sample)
		else $error("no new sample after completed conversion");
endmodule : sacp_sar_seq
`default_nettype wire

// ### rtl/sacp_adc_ctrl.sv
// APB-controlled SAR converter controller with power-fail comparison
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Only selected input routed; others stay port pins
// - Sample at start, hold until conversion ends
// - Decide one bit per step, MSB first
// - Copy final code to result every conversion
// - Result left-aligned, low six bits zero
// - Interrupt every conversion; with power-fail on, only when comparison holds
// - Mode register resets to zero, byte writable
// - Run bit stops or enables conversion
// - Time code selects conversion length in clocks
// - Bit zero switches boost reference on
// - Run and reference bits give converter state
// - Mode register write inserts a wait cycle
// - Channel field picks input in binary order
// - Compare upper eight bits, direction selects sense
// - Convert back to back while run set
// - Control register write aborts and restarts conversion
module sacp_adc_ctrl (
	input wire logic core_clk, // Converter clock
	input wire logic rst, // Async reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic comp_ge, // Comparator decision
	output sacp_pkg::sacp_afe_t afe, // Sample/hold and tap code
	output logic [7:0] route_en, // Analog switch per input
	output logic [7:0] port_in_en, // Digital input buffer per pin
	output logic [2:0] route_sel, // Selected input number
	output logic ref_boost_enable, // Boost reference generator on
	output sacp_pkg::sacp_conv_state_t conv_state, // Stop, waiting or converting
	output logic conv_done_irq // Conversion-done interrupt pulse
);
	sacp_pkg::sacp_mode_t converter_mode_reg;
	logic [2:0] channel_select_reg;
	sacp_pkg::sacp_pf_t powerfail_mode_reg;
	logic [7:0] powerfail_threshold_reg;
	logic [9:0] conv_result_reg;
	logic [31:0] prdata_reg;
	logic wait_done_reg;
	logic conv_done_irq_reg;

	wire logic [15:0] idx;
	wire logic addr_ok;
	wire logic sel_mode;
	wire logic sel_chan;
	wire logic sel_pf;
	wire logic sel_thr;
	wire logic sel_res;
	wire logic mapped;
	wire logic access;
	wire logic wr_wait_sel;
	wire logic wait_req;
	wire logic wr_fire;
	wire logic restart;
	wire logic we_mode;
	wire logic we_chan;
	wire logic we_pf;
	wire logic we_thr;
	wire logic [9:0] result_now;
	wire logic done;
	wire logic thr_ge;
	wire logic irq_cond;
	logic [31:0] rd_mux;

	// Address decode
	assign idx = paddr[17:2];
	assign addr_ok = paddr[31:18] == 14'h0000 && paddr[1:0] == 2'h0;
	assign sel_mode = addr_ok && idx == sacp_pkg::IDX_MODE;
	assign sel_chan = addr_ok && idx == sacp_pkg::IDX_CHAN;
	assign sel_pf = addr_ok && idx == sacp_pkg::IDX_PFMODE;
	assign sel_thr = addr_ok && idx == sacp_pkg::IDX_THRESH;
	assign sel_res = addr_ok && idx == sacp_pkg::IDX_RESULT;
	assign mapped = sel_mode | sel_chan | sel_pf | sel_thr | sel_res;
	assign access = psel && penable;
	assign wr_wait_sel = sel_mode | sel_chan | sel_pf | sel_thr;

	// Writes to control registers and result reads cost one wait state
	assign wait_req = access && (pwrite ? wr_wait_sel : sel_res);
	assign pready = !wait_req || wait_done_reg;
	assign pslverr = access && !mapped;
	assign prdata = prdata_reg;
	// Byte lane 0 carries every 8-bit register
	assign wr_fire = access && pready && pwrite && pstrb[0] && mapped;
	assign restart = wr_fire && wr_wait_sel;
	assign we_mode = wr_fire && sel_mode;
	assign we_chan = wr_fire && sel_chan;
	assign we_pf = wr_fire && sel_pf;
	assign we_thr = wr_fire && sel_thr;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_mode) begin
			rd_mux[sacp_pkg::MODE_RUN_BIT] = converter_mode_reg.run;
			rd_mux[sacp_pkg::MODE_TSEL_LSB +: 3] = converter_mode_reg.tsel;
			rd_mux[sacp_pkg::MODE_REF_BIT] = converter_mode_reg.ref_en;
		end else if (sel_chan) begin
			rd_mux[2:0] = channel_select_reg;
		end else if (sel_pf) begin
			rd_mux[sacp_pkg::PF_EN_BIT] = powerfail_mode_reg.en;
			rd_mux[sacp_pkg::PF_DIR_BIT] = powerfail_mode_reg.dir;
		end else if (sel_thr) begin
			rd_mux[7:0] = powerfail_threshold_reg;
		end else if (sel_res) begin
			rd_mux[15:0] = {conv_result_reg, {sacp_pkg::PAD_W{1'b0}}};
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdata_reg <= 32'h0000_0000;
			wait_done_reg <= 1'b0;
		end else begin
			if (psel && !penable)
				prdata_reg <= rd_mux;
			wait_done_reg <= access && !pready;
		end
	end

	// Control registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			converter_mode_reg <= '0;
		end else if (we_mode) begin
			converter_mode_reg.run <= pwdata[sacp_pkg::MODE_RUN_BIT];
			converter_mode_reg.tsel <= pwdata[sacp_pkg::MODE_TSEL_LSB +: 3];
			converter_mode_reg.ref_en <= pwdata[sacp_pkg::MODE_REF_BIT];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			channel_select_reg <= 3'h0;
		else if (we_chan)
			channel_select_reg <= pwdata[2:0];
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			powerfail_mode_reg <= '0;
		end else if (we_pf) begin
			powerfail_mode_reg.en <= pwdata[sacp_pkg::PF_EN_BIT];
			powerfail_mode_reg.dir <= pwdata[sacp_pkg::PF_DIR_BIT];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			powerfail_threshold_reg <= sacp_pkg::RESET_BYTE;
		else if (we_thr)
			powerfail_threshold_reg <= pwdata[7:0];
	end

	sacp_sar_seq u_seq (
		.core_clk(core_clk),
		.rst(rst),
		.run(converter_mode_reg.run),
		.restart(restart),
		.tsel(converter_mode_reg.tsel),
		.comp_ge(comp_ge),
		.afe(afe),
		.result_now(result_now),
		.done(done)
	);

	// Power-fail comparison on the fresh result's upper byte
	assign thr_ge = result_now[9:2] >= powerfail_threshold_reg;
	assign irq_cond = !powerfail_mode_reg.en || (powerfail_mode_reg.dir ? !thr_ge : thr_ge);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			conv_result_reg <= 10'h000;
			conv_done_irq_reg <= 1'b0;
		end else begin
			if (done)
				conv_result_reg <= result_now;
			conv_done_irq_reg <= done && irq_cond;
		end
	end
	assign conv_done_irq = conv_done_irq_reg;

	// Input routing: the analog switch closes only on the selected pin
	assign route_sel = channel_select_reg;
	genvar ch;
	generate
		for (ch = 0; ch < sacp_pkg::NCHAN; ch++) begin : g_route
			assign route_en[ch] = converter_mode_reg.run && channel_select_reg == 3'(ch);
			assign port_in_en[ch] = !route_en[ch];
		end
	endgenerate

	assign ref_boost_enable = converter_mode_reg.ref_en;
	assign conv_state = converter_mode_reg.run ? sacp_pkg::st_run :
		(converter_mode_reg.ref_en ? sacp_pkg::st_wait : sacp_pkg::st_stop);

	chk_route_onehot: assert property (@(posedge core_clk) disable iff (rst)
		$onehot0(route_en) && (port_in_en == ~route_en))
		else $error("more than one input routed");
	chk_chan_route: assert property (@(posedge core_clk) disable iff (rst)
		converter_mode_reg.run |-> route_en == (8'h01 << channel_select_reg))
		else $error("routed input does not match channel field");
	chk_result_copy: assert property (@(posedge core_clk) disable iff (rst)
		done |=> conv_result_reg == $past(result_now))
		else $error("result not transferred at conversion end");
	chk_result_pad: assert property (@(posedge core_clk) disable iff (rst)
		access && !pwrite && sel_res && pready |-> prdata[5:0] == 6'h00 &&
		prdata[15:6] == $past(conv_result_reg, 2))
		else $error("result read not left aligned");
	chk_irq_cond: assert property (@(posedge core_clk) disable iff (rst)
		conv_done_irq |-> $past(done) && (!$past(powerfail_mode_reg.en) ||
		($past(powerfail_mode_reg.dir) != ($past(result_now[9:2]) >= $past(powerfail_threshold_reg)))))
		else $error("interrupt raised without matching comparison");
	chk_irq_plain: assert property (@(posedge core_clk) disable iff (rst)
		done && !powerfail_mode_reg.en |=> conv_done_irq)
		else $error("interrupt missing in plain conversion mode");
	chk_mode_reset: assert property (@(posedge core_clk)
		$fell(rst) |-> converter_mode_reg == '0)
		else $error("mode register not cleared by reset");
	chk_run_stop: assert property (@(posedge core_clk) disable iff (rst)
		!converter_mode_reg.run |=> !afe.sample && !afe.hold)
		else $error("converter active with run bit clear");
	chk_mode_wait: assert property (@(posedge core_clk) disable iff (rst)
		psel && !penable && pwrite && sel_mode ##1 access |-> !pready ##1 pready)
		else $error("mode write without exactly one wait cycle");
	chk_abort_restart: assert property (@(posedge core_clk) disable iff (rst)
		restart |=> !afe.sample && !afe.hold ##1 (afe.sample == converter_mode_reg.run))
		else $error("write did not abort and restart conversion");
	chk_state_map: assert property (@(posedge core_clk) disable iff (rst)
		(conv_state == sacp_pkg::st_wait) |-> ref_boost_enable && !afe.sample && !afe.hold)
		else $error("waiting state while converting");

	// Register write effects
	chk_run_write: assert property (@(posedge core_clk) disable iff (rst)
		we_mode |=> converter_mode_reg.run == $past(pwdata[sacp_pkg::MODE_RUN_BIT]))
		else $error("run bit does not follow mode write");
	chk_tsel_write: assert property (@(posedge core_clk) disable iff (rst)
		we_mode |=> converter_mode_reg.tsel ==
		$past(pwdata[sacp_pkg::MODE_TSEL_LSB +: 3]))
		else $error("time code does not follow mode write");
	chk_ref_write: assert property (@(posedge core_clk) disable iff (rst)
		we_mode |=> ref_boost_enable == $past(pwdata[sacp_pkg::MODE_REF_BIT]))
		else $error("boost reference does not follow bit zero");
	chk_mode_hold: assert property (@(posedge core_clk) disable iff (rst)
		!we_mode |=> $stable(converter_mode_reg))
		else $error("mode register changed without a mode write");
	chk_chan_write: assert property (@(posedge core_clk) disable iff (rst)
		we_chan |=> channel_select_reg == $past(pwdata[2:0]))
		else $error("channel field does not follow write");
	chk_pf_write: assert property (@(posedge core_clk) disable iff (rst)
		we_pf |=> powerfail_mode_reg.en == $past(pwdata[sacp_pkg::PF_EN_BIT]) &&
		powerfail_mode_reg.dir == $past(pwdata[sacp_pkg::PF_DIR_BIT]))
		else $error("power-fail mode does not follow write");
	chk_thr_write: assert property (@(posedge core_clk) disable iff (rst)
		we_thr |=> powerfail_threshold_reg == $past(pwdata[7:0]))
		else $error("threshold does not follow write");
	chk_fixed_wait: assert property (@(posedge core_clk) disable iff (rst)
		psel && !penable && pwrite && (sel_chan || sel_pf || sel_thr) ##1 access |->
		!pready ##1 pready)
		else $error("control write without exactly one wait cycle");

	// Conversion and interrupt checks
	chk_abort_other: assert property (@(posedge core_clk) disable iff (rst)
		(we_chan || we_pf || we_thr) |=> !afe.sample && !afe.hold)
		else $error("register write did not abort conversion");
	chk_sample_first: assert property (@(posedge core_clk) disable iff (rst)
		$rose(afe.hold) |-> $past(afe.sample))
		else $error("hold entered without a sample phase");
	chk_lsb_last: assert property (@(posedge core_clk) disable iff (rst)
		done |-> afe.hold && afe.dac_code[0])
		else $error("conversion did not end on the LSB trial");
	chk_result_hold: assert property (@(posedge core_clk) disable iff (rst)
		!done |=> $stable(conv_result_reg))
		else $error("result changed outside conversion end");
	chk_irq_pulse: assert property (@(posedge core_clk) disable iff (rst)
		conv_done_irq |=> !conv_done_irq)
		else $error("interrupt longer than one cycle");
	chk_pf_ge: assert property (@(posedge core_clk) disable iff (rst)
		done && powerfail_mode_reg.en && !powerfail_mode_reg.dir &&
		result_now[9:2] >= powerfail_threshold_reg |=> conv_done_irq)
		else $error("interrupt missing at or above threshold");
	chk_pf_lt: assert property (@(posedge core_clk) disable iff (rst)
		done && powerfail_mode_reg.en && powerfail_mode_reg.dir &&
		result_now[9:2] < powerfail_threshold_reg |=> conv_done_irq)
		else $error("interrupt missing below threshold");

	// State and routing checks
	chk_route_idle: assert property (@(posedge core_clk) disable iff (rst)
		!converter_mode_reg.run |-> route_en == 8'h00 && port_in_en == 8'hff)
		else $error("input routed while conversion stopped");
	chk_state_stop: assert property (@(posedge core_clk) disable iff (rst)
		!converter_mode_reg.run && !converter_mode_reg.ref_en |->
		conv_state == sacp_pkg::st_stop && !ref_boost_enable)
		else $error("stop state not shown with both bits clear");
	chk_state_run: assert property (@(posedge core_clk) disable iff (rst)
		converter_mode_reg.run |-> conv_state == sacp_pkg::st_run)
		else $error("conversion state not shown with run set");
endmodule : sacp_adc_ctrl
`default_nettype wire

// ### tb/sacp_afe_model.sv
// Behavioural sample-and-hold and comparator facing the converter controller
`timescale 1ns/1ns
`default_nettype none
module sacp_afe_model (
	input wire logic core_clk, // Converter clock
	input wire logic rst, // Async reset, active high
	input wire sacp_pkg::sacp_afe_t afe, // Sample/hold and tap code
	input wire logic [7:0][9:0] ain, // Input levels as ideal codes
	input wire logic [2:0] route_sel, // Selected input
	output logic comp_ge // Comparator decision
);
	logic [9:0] held_reg;
	logic junk_reg;
	// Outside hold the decision means nothing, so it wanders
	assign comp_ge = afe.hold ? (held_reg >= afe.dac_code) : junk_reg;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			held_reg <= 10'h000;
			junk_reg <= 1'b0;
		end else begin
			junk_reg <= ~junk_reg;
			if (afe.sample) begin
				held_reg <= ain[route_sel];
			end
		end
	end
endmodule : sacp_afe_model
`default_nettype wire

// ### tb/sacp_adc_ctrl_tb.sv
// Register-level testbench for the converter controller
`timescale 1ns/1ns
`default_nettype none
module sacp_adc_ctrl_tb;
	logic core_clk, rst, psel, penable, pwrite, pready, pslverr, comp_ge;
	logic ref_boost_enable, conv_done_irq, g;
	logic [31:0] paddr, pwdata, prdata;
	logic [3:0] pstrb;
	logic [7:0] route_en, port_in_en;
	logic [2:0] route_sel;
	logic [7:0][9:0] ain;
	sacp_pkg::sacp_afe_t afe;
	sacp_pkg::sacp_conv_state_t conv_state;
	int n_fail, cmp_count, i, c;
	logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
	logic [8:0] lens [6] = '{9'h120, 9'h0f0, 9'h0c0, 9'h090, 9'h078, 9'h060};
	logic [7:0] pf_modes [4] = '{8'h80, 8'h80, 8'hc0, 8'hc0};
	logic [7:0] pf_limits [4] = '{8'haa, 8'ha9, 8'ha9, 8'haa};
	logic pexp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

	sacp_adc_ctrl dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .comp_ge(comp_ge), .afe(afe),
		.route_en(route_en), .port_in_en(port_in_en), .route_sel(route_sel),
		.ref_boost_enable(ref_boost_enable), .conv_state(conv_state),
		.conv_done_irq(conv_done_irq));
	sacp_afe_model far_end (.core_clk(core_clk), .rst(rst), .afe(afe), .ain(ain),
		.route_sel(route_sel), .comp_ge(comp_ge));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {14'h0000, idx, 2'b00};
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		// Wait for the slave; only the watchdog ends a hung access
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, idx, {24'h00_0000, d}, r, e);
	endtask : wr

	task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic exp_err);
		logic [31:0] r;
		logic e;
		apb(1'b0, idx, 32'h0000_0000, r, e);
		chk(r, exp);
		chk({31'h0000_0000, e}, {31'h0000_0000, exp_err});
	endtask : rd

	// Bounded wait for the interrupt pulse; got tells whether it came
	task automatic wait_irq(input int lim, output int cyc, output logic got);
		cyc = 0;
		do begin
			@(posedge core_clk);
			cyc++;
		end while (conv_done_irq !== 1'b1 && cyc < lim);
		got = (conv_done_irq === 1'b1);
	endtask : wait_irq

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (50000) @(posedge core_clk);
		n_fail++;
		give_verdict();
	end

	initial begin
		rst = 1'b1;
		{psel, penable, pwrite} = 3'h0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hf;
		for (i = 0; i < 8; i++) begin
			ain[i] = 10'h155;
		end
		ain[5] = 10'h2a5;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		rd(sacp_pkg::IDX_MODE, 32'h0000_0000, 1'b0);
		rd(sacp_pkg::IDX_CHAN, 32'h0000_0000, 1'b0);
		rd(sacp_pkg::IDX_PFMODE, 32'h0000_0000, 1'b0);
		rd(sacp_pkg::IDX_THRESH, 32'h0000_0000, 1'b0);
		wr(sacp_pkg::IDX_RESULT, 8'hff);
		rd(sacp_pkg::IDX_RESULT, 32'h0000_0000, 1'b0);
		rd(16'hff30, 32'h0000_0000, 1'b1);
		chk({30'h0000_0000, conv_state}, {30'h0000_0000, sacp_pkg::st_stop});
		chk({24'h00_0000, port_in_en}, 32'h0000_00ff);
		$display("test reset values done");
		wr(sacp_pkg::IDX_CHAN, 8'h05);
		wr(sacp_pkg::IDX_MODE, 8'h01);
		// Outputs of the write edge settle only after it
		@(negedge core_clk);
		chk({31'h0000_0000, ref_boost_enable}, 32'h0000_0001);
		chk({30'h0000_0000, conv_state}, {30'h0000_0000, sacp_pkg::st_wait});
		// Let the boost reference settle before running
		repeat (1750) @(posedge core_clk);
		for (i = 0; i < 6; i++) begin
			wr(sacp_pkg::IDX_MODE, 8'h01);
			wr(sacp_pkg::IDX_MODE, {2'b10, codes[i], 3'b001}); // Legal codes only
			wait_irq(700, c, g); // First result discarded
			chk({31'h0000_0000, g}, 32'h0000_0001);
			chk({30'h0000_0000, afe.sample, afe.hold}, 32'h0000_0002);
			wait_irq(700, c, g);
			chk(c, {23'h00_0000, lens[i]});
			rd(sacp_pkg::IDX_RESULT, {16'h0000, ain[5], 6'h00}, 1'b0);
		end
		chk({24'h00_0000, route_en}, 32'h0000_0020);
		chk({24'h00_0000, port_in_en}, 32'h0000_00df);
		chk({29'h0000_0000, route_sel}, 32'h0000_0005);
		chk({30'h0000_0000, conv_state}, {30'h0000_0000, sacp_pkg::st_run});
		rd(sacp_pkg::IDX_MODE, 32'h0000_00b1, 1'b0);
		$display("test conversion timing done");
		wait_irq(700, c, g);
		repeat (40) @(posedge core_clk);
		wr(sacp_pkg::IDX_THRESH, 8'h00);
		wait_irq(700, c, g);
		chk({31'h0000_0000, c >= 96}, 32'h0000_0001);
		$display("test abort done");
		for (i = 0; i < 4; i++) begin
			wr(sacp_pkg::IDX_PFMODE, pf_modes[i]);
			wr(sacp_pkg::IDX_THRESH, pf_limits[i]);
			wait_irq(250, c, g);
			chk({31'h0000_0000, g}, {31'h0000_0000, pexp[i]});
		end
		$display("test power-fail compare done");
		wr(sacp_pkg::IDX_MODE, 8'h00);
		wait_irq(300, c, g);
		chk({31'h0000_0000, g}, 32'h0000_0000);
		chk({20'h0_0000, afe}, 32'h0000_0000);
		chk({30'h0000_0000, conv_state}, {30'h0000_0000, sacp_pkg::st_stop});
		$display("test stop done");
		give_verdict();
	end
endmodule : sacp_adc_ctrl_tb
`default_nettype wire
